//--- testbench/acp_host_model.sv
// Host-side model: sampling clock, serial port and calibration request pins.
// Assumes a free-running master clock; every pin changes on its falling edge.
`timescale 1ns/1ps
module acp_host_model #(
  parameter int HALF = 4
) (
  // Master clock
  input wire logic i_mclk,
  // Pins towards the converter
  output logic o_sample_clock,
  output logic o_serial_clock,
  output logic o_serial_data,
  output logic o_port_select_n,
  output logic o_trim_request
);
  int ph;

  initial begin
    o_sample_clock = 1'h0;
    o_serial_clock = 1'h0;
    o_serial_data = 1'h0;
    o_port_select_n = 1'h1;
    o_trim_request = 1'h1;
  end

  // ----------------------------------------------------------------
  // Sampling clock
  // ----------------------------------------------------------------
  // Each level lasts HALF master cycles, slow enough for the pin filters.
  always @(negedge i_mclk) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) begin
      o_sample_clock <= ~o_sample_clock;
    end
  end

  // ----------------------------------------------------------------
  // Host operations
  // ----------------------------------------------------------------
  // Sends the first nbits of a frame; fewer than 20 leaves it unfinished.
  task automatic frame(input logic [19:0] bits, input int nbits);
    // Select stays high long enough for the pin filter to see a gap between frames.
    repeat (HALF) @(negedge i_mclk);
    o_port_select_n <= 1'h0;
    for (int i = 19; i > 19 - nbits; i--) begin
      o_serial_data <= bits[i];
      repeat (HALF) @(negedge i_mclk);
      o_serial_clock <= 1'h1;
      repeat (HALF) @(negedge i_mclk);
      o_serial_clock <= 1'h0;
    end
    repeat (HALF) @(negedge i_mclk);
    o_port_select_n <= 1'h1;
    // A released data line does not keep its last value.
    o_serial_data <= ~o_serial_data;
  endtask : frame

  // Request held low, then high, for the given counts of sampling edges.
  task automatic trim_request(input int n_low, input int n_high);
    @(negedge i_mclk);
    o_trim_request <= 1'h0;
    repeat (n_low) @(posedge o_sample_clock);
    @(negedge i_mclk);
    o_trim_request <= 1'h1;
    repeat (n_high) @(posedge o_sample_clock);
  endtask : trim_request
endmodule : acp_host_model

//--- testbench/test_adc_control_pin_logic.sv
// Self-checking bench of the converter control-pin logic.
// Assumes the host model drives the sampling clock, serial port and request.
`timescale 1ns/1ps
`include "acp_params.svh"
module test_adc_control_pin_logic;
  import acp_pkg::*;
  localparam int SHORT = 4;
  localparam int LONG = 12;
  localparam int TRIM = 6;
  logic mclk, rst, range_level, range_float, delay_sel, resync, resync_diff;
  logic smp, sck, sdat, sel_n, treq, dual, trim, ext, strobe, data_clk, s1, s0;
  logic [`ACP_RANGE_W-1:0] range;
  int n_mismatch, n_tests, n, n_strobe;

  // The dual pin is chip select in extended mode, delay select otherwise.
  assign dual = range_float ? sel_n : delay_sel;

  acp_control #(.SHORT_DELAY(SHORT), .LONG_DELAY(LONG), .TRIM_CYCLES(TRIM),
    .CAL_MIN(`ACP_CAL_MIN_CYCLES)) i_acp_control (.I_MCLK(mclk), .I_RST(rst),
    .I_SAMPLE_CLOCK(smp), .I_TRIM_REQUEST(treq),
    .I_RANGE_OR_EXTENDED_MODE_PIN_LEVEL(range_level),
    .I_RANGE_OR_EXTENDED_MODE_PIN_FLOAT(range_float),
    .I_TRIM_DELAY_OR_PORT_SELECT(dual), .I_SERIAL_CLOCK(sck), .I_SERIAL_DATA(sdat),
    .I_OUTPUT_CLOCK_RESYNC(resync), .I_OUTPUT_CLOCK_RESYNC_DIFF(resync_diff),
    .O_TRIM_IN_PROGRESS(trim), .O_EXTENDED_MODE(ext), .O_INPUT_RANGE_SELECT(range),
    .O_SAMPLE_STROBE(strobe), .O_OUTPUT_DATA_CLOCK(data_clk));

  acp_host_model i_acp_host_model (.i_mclk(mclk), .o_sample_clock(smp),
    .o_serial_clock(sck), .o_serial_data(sdat), .o_port_select_n(sel_n),
    .o_trim_request(treq));

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_in

  // Counts sampling rising edges until the trim flag reaches v.
  task automatic edges_until(input logic v, input int maxe);
    n = 0;
    while (trim !== v && n < maxe) begin
      @(posedge smp);
      n++;
    end
  endtask : edges_until

  // Notes data clock levels and counts strobes over cyc master cycles.
  task automatic watch(input int cyc);
    s1 = 1'h0;
    s0 = 1'h0;
    n_strobe = 0;
    repeat (cyc) begin
      @(negedge mclk);
      s1 |= (data_clk === 1'h1);
      s0 |= (data_clk === 1'h0);
      n_strobe += (strobe === 1'h1);
    end
  endtask : watch

  task automatic do_reset(input logic flt, input logic dly);
    @(negedge mclk);
    rst = 1'h1;
    range_float = flt;
    delay_sel = dly;
    repeat (2) @(negedge mclk);
    chk(16'({trim, ext, strobe, data_clk, range}), 16'h0000);
    rst = 1'h0;
  endtask : do_reset

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    #(25 * 30000);
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    rst = 1'h1;
    range_level = 1'h0;
    range_float = 1'h0;
    delay_sel = 1'h1;
    resync = 1'h0;
    resync_diff = 1'h0;
    n_mismatch = 0;
    n_tests = 0;
    do_reset(1'h0, 1'h1);
    edges_until(1'h1, 40);
    chk_in(n, LONG - 1, LONG + 3);
    edges_until(1'h0, 40);
    chk_in(n, TRIM - 1, TRIM + 2);
    do_reset(1'h1, 1'h1);
    edges_until(1'h1, 40);
    chk_in(n, SHORT - 1, SHORT + 3);
    edges_until(1'h0, 40);
    chk(16'(ext), 16'h0001);
    chk(16'(range), 16'h0100);
    range_level = 1'h1;
    repeat (8) @(negedge mclk);
    chk(16'(range), 16'h0100);
    i_acp_host_model.frame({4'h3, 16'hABCD}, 20);
    repeat (8) @(negedge mclk);
    chk(16'(range), 16'h0157);
    i_acp_host_model.frame({4'h2, 16'h0000}, 20);
    i_acp_host_model.frame({4'h3, 16'h0000}, 12);
    repeat (8) @(negedge mclk);
    chk(16'(range), 16'h0157);
    // Single-ended resync selected after reset, then the differential pair.
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        i_acp_host_model.frame({4'h1, 16'h4000}, 20);
      end
      resync = (k == 0);
      resync_diff = (k == 1);
      watch(8);
      watch(24);
      chk(16'(s1), 16'h0000);
      resync = 1'h0;
      resync_diff = 1'h0;
      watch(20);
      chk(16'(s1), 16'h0001);
      resync = (k == 1);
      resync_diff = (k == 0);
      watch(80);
      chk(16'({s1, s0}), 16'h0003);
      chk(16'(n_strobe), 16'h0014);
      resync = 1'h0;
      resync_diff = 1'h0;
    end
    i_acp_host_model.trim_request(82, 40);
    i_acp_host_model.trim_request(82, 0);
    edges_until(1'h1, 120);
    chk_in(n, `ACP_CAL_MIN_CYCLES - 1, `ACP_CAL_MIN_CYCLES + 4);
    edges_until(1'h0, 40);
    chk_in(n, TRIM - 1, TRIM + 2);
    range_float = 1'h0;
    range_level = 1'h0;
    delay_sel = 1'h0;
    repeat (8) @(negedge mclk);
    chk(16'({ext, range}), 16'h0000);
    range_level = 1'h1;
    repeat (8) @(negedge mclk);
    chk(16'(range), 16'h01FF);
    i_acp_host_model.frame({4'h3, 16'h0000}, 20);
    range_float = 1'h1;
    repeat (8) @(negedge mclk);
    chk(16'(range), 16'h0157);
    do_reset(1'h0, 1'h0);
    edges_until(1'h1, 40);
    chk_in(n, SHORT - 1, SHORT + 3);
    edges_until(1'h0, 40);
    range_float = 1'h1;
    repeat (8) @(negedge mclk);
    chk(16'(range), 16'h0100);
    results();
  end
endmodule : test_adc_control_pin_logic

//--- verilog/acp_control.sv
// Control-pin logic of the converter: mode, range, calibration, resync.
// Assumes all pins are asynchronous to I_MCLK and far slower than it.
`timescale 1ns/1ps
`include "acp_params.svh"
module acp_control
  import acp_pkg::*;
#(
  parameter int SHORT_DELAY = `ACP_SHORT_DELAY_CYCLES,
  parameter int LONG_DELAY = `ACP_LONG_DELAY_CYCLES,
  parameter int TRIM_CYCLES = `ACP_TRIM_CYCLES,
  parameter int CAL_MIN = `ACP_CAL_MIN_CYCLES
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // Sampling clock and calibration request pins
  input wire logic I_SAMPLE_CLOCK,
  input wire logic I_TRIM_REQUEST,
  // Mode, range and dual-purpose pins
  input wire logic I_RANGE_OR_EXTENDED_MODE_PIN_LEVEL,
  input wire logic I_RANGE_OR_EXTENDED_MODE_PIN_FLOAT,
  input wire logic I_TRIM_DELAY_OR_PORT_SELECT,
  // Serial configuration port
  input wire logic I_SERIAL_CLOCK,
  input wire logic I_SERIAL_DATA,
  // Resync inputs
  input wire logic I_OUTPUT_CLOCK_RESYNC,
  input wire logic I_OUTPUT_CLOCK_RESYNC_DIFF,
  // Status and control outputs
  output logic O_TRIM_IN_PROGRESS,
  output logic O_EXTENDED_MODE,
  output logic [`ACP_RANGE_W-1:0] O_INPUT_RANGE_SELECT,
  output logic O_SAMPLE_STROBE,
  output logic O_OUTPUT_DATA_CLOCK
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [`ACP_ADDR_W-1:0] addr,
                                   input logic [`ACP_ADDR_W-1:0] target);
    reg_hit = (addr == target);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic smp_lvl, req_lvl, rng_lvl, flt_lvl, dual_lvl, sck_lvl, sda_lvl, rs_se_lvl, rs_df_lvl;

  acp_sync u_sync_smp (.i_clk(I_MCLK), .i_rst(I_RST), .i_pin(I_SAMPLE_CLOCK), .o_level(smp_lvl));
  acp_sync u_sync_req (.i_clk(I_MCLK), .i_rst(I_RST), .i_pin(I_TRIM_REQUEST), .o_level(req_lvl));
  acp_sync u_sync_rng (.i_clk(I_MCLK), .i_rst(I_RST),
                       .i_pin(I_RANGE_OR_EXTENDED_MODE_PIN_LEVEL), .o_level(rng_lvl));
  acp_sync u_sync_flt (.i_clk(I_MCLK), .i_rst(I_RST),
                       .i_pin(I_RANGE_OR_EXTENDED_MODE_PIN_FLOAT), .o_level(flt_lvl));
  acp_sync u_sync_dual (.i_clk(I_MCLK), .i_rst(I_RST),
                        .i_pin(I_TRIM_DELAY_OR_PORT_SELECT), .o_level(dual_lvl));
  acp_sync u_sync_sck (.i_clk(I_MCLK), .i_rst(I_RST), .i_pin(I_SERIAL_CLOCK), .o_level(sck_lvl));
  acp_sync u_sync_sda (.i_clk(I_MCLK), .i_rst(I_RST), .i_pin(I_SERIAL_DATA), .o_level(sda_lvl));
  acp_sync u_sync_rse (.i_clk(I_MCLK), .i_rst(I_RST),
                       .i_pin(I_OUTPUT_CLOCK_RESYNC), .o_level(rs_se_lvl));
  acp_sync u_sync_rdf (.i_clk(I_MCLK), .i_rst(I_RST),
                       .i_pin(I_OUTPUT_CLOCK_RESYNC_DIFF), .o_level(rs_df_lvl));

  // ----------------------------------------------------------------
  // Edge detection on filtered levels
  // ----------------------------------------------------------------
  logic smp_prev_reg, sck_prev_reg, smp_rise, smp_edge, sck_rise;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      smp_prev_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      smp_prev_reg <= smp_lvl;
      sck_prev_reg <= sck_lvl;
    end
  end

  assign smp_rise = smp_lvl && !smp_prev_reg;
  assign smp_edge = smp_lvl != smp_prev_reg;
  assign sck_rise = sck_lvl && !sck_prev_reg;

  // ----------------------------------------------------------------
  // Mode and dual-purpose pin
  // ----------------------------------------------------------------
  logic ext_mode, port_select, delay_select;

  assign ext_mode = flt_lvl;
  assign port_select = ext_mode && !dual_lvl;
  assign delay_select = ext_mode ? 1'b0 : dual_lvl;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic wr;
  logic [`ACP_ADDR_W-1:0] wr_addr;
  logic [`ACP_DATA_W-1:0] wr_data, device_configuration_reg, full_scale_adjust_reg;

  acp_serial u_serial (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_select(port_select),
    .i_sclk_rise(sck_rise),
    .i_sdata(sda_lvl),
    .o_wr(wr),
    .o_addr(wr_addr),
    .o_data(wr_data)
  );

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      device_configuration_reg <= `ACP_CFG_RESET;
      full_scale_adjust_reg <= `ACP_FSA_RESET;
    end else if (wr) begin
      if (reg_hit(wr_addr, `ACP_CFG_ADDR)) begin
        device_configuration_reg <= wr_data;
      end
      if (reg_hit(wr_addr, `ACP_FSA_ADDR)) begin
        full_scale_adjust_reg <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Full-scale range
  // ----------------------------------------------------------------
  logic [`ACP_RANGE_W-1:0] range_next;

  always_comb begin
    if (ext_mode) begin
      range_next = full_scale_adjust_reg[`ACP_FSA_MSB:`ACP_FSA_LSB];
    end else if (rng_lvl) begin
      range_next = `ACP_RANGE_CODE_820;
    end else begin
      range_next = `ACP_RANGE_CODE_600;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_INPUT_RANGE_SELECT <= `ACP_RANGE_CODE_600;
      O_EXTENDED_MODE <= 1'b0;
    end else begin
      O_INPUT_RANGE_SELECT <= range_next;
      O_EXTENDED_MODE <= ext_mode;
    end
  end

  // ----------------------------------------------------------------
  // Dual-edge sampling strobe
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_SAMPLE_STROBE <= 1'b0;
    end else begin
      O_SAMPLE_STROBE <= smp_edge;
    end
  end

  // ----------------------------------------------------------------
  // Output data clock and resync
  // ----------------------------------------------------------------
  logic resync;

  assign resync = device_configuration_reg[`ACP_CFG_RESYNC_DIFF_BIT] ? rs_df_lvl
                                                                      : rs_se_lvl;

  // The clock restarts on the first sampling rising edge after the pulse.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_OUTPUT_DATA_CLOCK <= 1'b0;
    end else if (resync) begin
      O_OUTPUT_DATA_CLOCK <= 1'b0;
    end else if (smp_rise) begin
      O_OUTPUT_DATA_CLOCK <= !O_OUTPUT_DATA_CLOCK;
    end
  end

  // ----------------------------------------------------------------
  // On-command calibration request
  // ----------------------------------------------------------------
  logic [7:0] req_low_reg, req_high_reg;
  logic req_start;

  assign req_start = smp_rise && req_lvl && (req_low_reg == 8'(CAL_MIN))
                     && (req_high_reg == 8'(CAL_MIN - 1));

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      req_low_reg <= 8'h00;
      req_high_reg <= 8'h00;
    end else if (smp_rise) begin
      if (!req_lvl) begin
        req_high_reg <= 8'h00;
        if (req_low_reg != 8'(CAL_MIN)) begin
          req_low_reg <= req_low_reg + 8'h01;
        end
      end else if (req_low_reg != 8'(CAL_MIN)) begin
        req_low_reg <= 8'h00;
      end else if (req_start) begin
        req_low_reg <= 8'h00;
        req_high_reg <= 8'h00;
      end else begin
        req_high_reg <= req_high_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  acp_trim_state_t state_reg, state_next;
  logic [23:0] count_reg, delay_target;
  logic delay_done, trim_done;

  assign delay_target = delay_select ? 24'(LONG_DELAY - 1) : 24'(SHORT_DELAY - 1);
  assign delay_done = smp_rise && (count_reg >= delay_target);
  assign trim_done = smp_rise && (count_reg == 24'(TRIM_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ACP_POWER_WAIT: begin
        if (delay_done) begin
          state_next = ACP_TRIM;
        end
      end
      ACP_IDLE: begin
        if (req_start) begin
          state_next = ACP_TRIM;
        end
      end
      ACP_TRIM: begin
        if (trim_done) begin
          state_next = ACP_IDLE;
        end
      end
      default: state_next = ACP_POWER_WAIT;
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ACP_POWER_WAIT;
      count_reg <= 24'h000000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        count_reg <= 24'h000000;
      end else if (smp_rise && state_reg != ACP_IDLE) begin
        count_reg <= count_reg + 24'h000001;
      end
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_TRIM_IN_PROGRESS <= 1'b0;
    end else begin
      O_TRIM_IN_PROGRESS <= (state_next == ACP_TRIM);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_delay_end;
    state_reg == ACP_POWER_WAIT && delay_done;
  endsequence
  sequence s_trim_running;
    state_reg == ACP_TRIM && O_TRIM_IN_PROGRESS;
  endsequence
  property p_trim_flag;
    O_TRIM_IN_PROGRESS == (state_reg == ACP_TRIM);
  endproperty
  a_trim_flag: assert property (p_trim_flag) else $error("trim flag disagrees with state");
  property p_trim_start;
    s_delay_end |=> s_trim_running;
  endproperty
  a_trim_start: assert property (p_trim_start) else $error("trim did not start");
  property p_trim_end;
    state_reg == ACP_TRIM && trim_done |=> !O_TRIM_IN_PROGRESS && state_reg == ACP_IDLE;
  endproperty
  a_trim_end: assert property (p_trim_end) else $error("trim did not end");
  property p_delay_forced;
    ext_mode |-> delay_target == 24'(SHORT_DELAY - 1) && !delay_select;
  endproperty
  a_delay_forced: assert property (p_delay_forced) else $error("delay not forced short");
  property p_select_gate;
    !ext_mode |-> !port_select;
  endproperty
  a_select_gate: assert property (p_select_gate) else $error("chip select outside ext mode");
  property p_range_pin;
    !ext_mode |=> O_INPUT_RANGE_SELECT ==
                  ($past(rng_lvl) ? `ACP_RANGE_CODE_820 : `ACP_RANGE_CODE_600);
  endproperty
  a_range_pin: assert property (p_range_pin) else $error("pin range wrong");
  property p_range_reg;
    ext_mode |=> O_INPUT_RANGE_SELECT == $past(full_scale_adjust_reg[`ACP_FSA_MSB:`ACP_FSA_LSB]);
  endproperty
  a_range_reg: assert property (p_range_reg) else $error("register range wrong");
  property p_strobe;
    smp_edge |=> O_SAMPLE_STROBE ##1 (O_SAMPLE_STROBE == $past(smp_edge));
  endproperty
  a_strobe: assert property (p_strobe) else $error("sample strobe missed an edge");
  property p_resync_diff;
    device_configuration_reg[`ACP_CFG_RESYNC_DIFF_BIT] && rs_df_lvl |=> !O_OUTPUT_DATA_CLOCK;
  endproperty
  a_resync_diff: assert property (p_resync_diff) else $error("diff resync ignored");
  property p_resync_se;
    !device_configuration_reg[`ACP_CFG_RESYNC_DIFF_BIT] && rs_se_lvl [*2] |=> !O_OUTPUT_DATA_CLOCK;
  endproperty
  a_resync_se: assert property (p_resync_se) else $error("single-ended resync ignored");

endmodule : acp_control

//--- verilog/acp_params.svh
// Constants for the converter control-pin logic.
// Assumes inclusion by bare name from the design files.
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ACP_ADDR_W 4
`define ACP_DATA_W 16
`define ACP_FRAME_BITS 20
`define ACP_CFG_ADDR 4'h1
`define ACP_FSA_ADDR 4'h3
`define ACP_CFG_RESET 16'h0000
`define ACP_FSA_RESET 16'h8000
`define ACP_CFG_RESYNC_DIFF_BIT 14
`define ACP_FSA_MSB 15
`define ACP_FSA_LSB 7

// ----------------------------------------------------------------
// Range codes and counts
// ----------------------------------------------------------------
`define ACP_RANGE_W 9
`define ACP_RANGE_CODE_600 9'h000
`define ACP_RANGE_CODE_820 9'h1FF
`define ACP_CAL_MIN_CYCLES 80
`define ACP_SHORT_DELAY_CYCLES 256
`define ACP_LONG_DELAY_CYCLES 4096
`define ACP_TRIM_CYCLES 1024

`endif

//--- verilog/acp_pkg.sv
// Types shared by the converter control-pin logic.
// Assumes nothing of its surroundings.
package acp_pkg;

  // ----------------------------------------------------------------
  // Calibration sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACP_POWER_WAIT,
    ACP_IDLE,
    ACP_TRIM
  } acp_trim_state_t;

endpackage : acp_pkg

//--- verilog/acp_serial.sv
// Serial write receiver for the configuration registers.
// Assumes a synchronised serial clock edge pulse and data level.
// Frame: address then data, most significant bit first.
`timescale 1ns/1ps
`include "acp_params.svh"
module acp_serial (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial port
  input wire logic i_select,
  input wire logic i_sclk_rise,
  input wire logic i_sdata,
  // Register write
  output logic o_wr,
  output logic [`ACP_ADDR_W-1:0] o_addr,
  output logic [`ACP_DATA_W-1:0] o_data
);

  logic [`ACP_FRAME_BITS-1:0] shift_reg;
  logic [4:0] count_reg;
  logic [`ACP_FRAME_BITS-1:0] frame_next;

  assign frame_next = {shift_reg[`ACP_FRAME_BITS-2:0], i_sdata};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_reg <= '0;
      count_reg <= 5'h00;
    end else if (!i_select) begin
      count_reg <= 5'h00;
    end else if (i_sclk_rise) begin
      shift_reg <= frame_next;
      if (count_reg == 5'(`ACP_FRAME_BITS - 1)) begin
        count_reg <= 5'h00;
      end else begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr <= 1'b0;
      o_addr <= '0;
      o_data <= '0;
    end else begin
      o_wr <= i_select && i_sclk_rise && (count_reg == 5'(`ACP_FRAME_BITS - 1));
      if (i_select && i_sclk_rise && (count_reg == 5'(`ACP_FRAME_BITS - 1))) begin
        o_addr <= frame_next[`ACP_FRAME_BITS-1:`ACP_DATA_W];
        o_data <= frame_next[`ACP_DATA_W-1:0];
      end
    end
  end

endmodule : acp_serial

//--- verilog/acp_sync.sv
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps
module acp_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pin
  input wire logic i_pin,
  // Filtered level
  output logic o_level
);

  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ff1_reg <= 1'b0;
      ff2_reg <= 1'b0;
      ff3_reg <= 1'b0;
    end else begin
      ff1_reg <= i_pin;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // A change is taken only once the second and third stages agree.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else if (ff2_reg == ff3_reg) begin
      o_level <= ff3_reg;
    end
  end

endmodule : acp_sync
